/* File: shared/asbc_pkg.sv */
package asbc_pkg;
	// pin and data widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	// clock rate and derived cycle counts
	localparam int CLK_PERIOD_NS = 8;
	// read access from address, least time before sampling data
	localparam int READ_ACCESS_NS = 85;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// write pulse width, least
	localparam int WRITE_PULSE_NS = 70;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// bus turnaround after output enable release, least
	localparam int TURN_NS = 30;
	localparam int TURN_CYC = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// retention recovery time in ms
	localparam int RETENTION_RECOVERY_TIME_MS = 5;
	localparam int RECOVERY_CYC_DEF = RETENTION_RECOVERY_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
endpackage

/* File: rtl/asbc_host.sv */
// What this block does
// - keep write strobe high throughout every read cycle.
// - release host data drivers before enabling the memory output.
// - read needs selects active, output enable low, strobe high, a lane enabled.
// - lower write: lower lane low, upper high; only low byte driven.
// - upper write: upper lane low, lower high; only high byte driven.
// - word write: both lanes low, sixteen bits stored together.
// - write timed by one strobe, other conditions held steady.
// - during retention keep memory deselected, no accesses.
`timescale 1ns/1ns
module asbc_host #(
	parameter int RECOVERY_CYC = asbc_pkg::RECOVERY_CYC_DEF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [asbc_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [asbc_pkg::DATA_W-1:0] req_wdata_i,
	input wire logic [1:0] req_lanes_i,
	input wire logic retention_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [asbc_pkg::DATA_W-1:0] rsp_rdata_o,
	output logic [asbc_pkg::ADDR_W-1:0] mem_addr_o,
	output logic select_low_active_n_o,
	output logic select_high_active_o,
	output logic out_en_n_o,
	output logic write_en_n_o,
	output logic lower_lane_en_n_o,
	output logic upper_lane_en_n_o,
	input wire logic [asbc_pkg::DATA_W-1:0] data_i,
	output logic [asbc_pkg::DATA_W-1:0] data_o,
	output logic [1:0] data_oe_n_o
);
	typedef enum logic [2:0] {ST_RECOVER, ST_IDLE, ST_READ, ST_WRITE, ST_TURN, ST_RETAIN}
		asbc_state_type;

	logic [1:0] rst_sync_r;
	logic rst_n;
	asbc_state_type state_r;
	asbc_state_type state_nxt;
	logic [asbc_pkg::CNT_W-1:0] cnt_r;
	logic [asbc_pkg::CNT_W-1:0] cnt_nxt;
	logic [asbc_pkg::ADDR_W-1:0] addr_r;
	logic [asbc_pkg::DATA_W-1:0] wdata_r;
	logic [asbc_pkg::DATA_W-1:0] rdata_r;
	logic [1:0] lanes_r;
	logic write_r;
	logic rsp_valid_r;
	logic sel_n_r;
	logic sel_r;
	logic oe_n_r;
	logic we_n_r;
	logic [1:0] lane_n_r;
	logic [1:0] doe_n_r;
	logic ready_r;

	// reset release through two flops
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	assign rst_n = rst_sync_r[1];

	// decode of the request and of the pin values each state wants
	wire cnt_done = (cnt_r == asbc_pkg::CNT_ZERO);
	wire lanes_any = (req_lanes_i != 2'h0);
	wire take = (state_r == ST_IDLE) && req_valid_i && lanes_any && !retention_i;
	wire in_access = (state_nxt == ST_READ) || (state_nxt == ST_WRITE);
	wire sel_n_nxt = !in_access;
	wire oe_n_nxt = (state_nxt != ST_READ);
	wire we_n_nxt = (state_nxt != ST_WRITE);
	// lane enables follow the requested width in both directions
	wire [1:0] lane_src = take ? req_lanes_i : lanes_r;
	wire [1:0] lane_n_nxt = in_access ? ~lane_src : 2'h3;
	// host drives only the written lanes and only while writing
	wire [1:0] doe_n_nxt = (state_nxt == ST_WRITE) ? ~lane_src : 2'h3;
	wire [asbc_pkg::DATA_W-1:0] wdata_nxt = take ? req_wdata_i : wdata_r;

	// sequencer
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_done ? cnt_r : cnt_r - asbc_pkg::CNT_ONE;
		unique case (state_r)
			ST_RECOVER:
				if (cnt_done)
					state_nxt = ST_IDLE;
			ST_IDLE:
				if (retention_i)
					state_nxt = ST_RETAIN;
				else if (take)
				begin
					state_nxt = req_write_i ? ST_WRITE : ST_READ;
					cnt_nxt = req_write_i ? asbc_pkg::CNT_W'(asbc_pkg::WRITE_PULSE_CYC - 1)
						: asbc_pkg::CNT_W'(asbc_pkg::READ_ACCESS_CYC - 1);
				end
			ST_READ:
				if (cnt_done)
				begin
					state_nxt = ST_TURN;
					cnt_nxt = asbc_pkg::CNT_W'(asbc_pkg::TURN_CYC - 1);
				end
			ST_WRITE:
				if (cnt_done)
					state_nxt = ST_IDLE;
			ST_TURN:
				if (cnt_done)
					state_nxt = ST_IDLE;
			ST_RETAIN:
				if (!retention_i)
				begin
					state_nxt = ST_RECOVER;
					cnt_nxt = asbc_pkg::CNT_W'(RECOVERY_CYC - 1);
				end
		endcase
	end

	// state and counter
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			state_r <= ST_RECOVER;
			cnt_r <= asbc_pkg::CNT_W'(RECOVERY_CYC - 1);
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end

	// request capture, held for the whole cycle
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			addr_r <= asbc_pkg::ADDR_RESET;
			lanes_r <= 2'h0;
			write_r <= 1'b0;
		end
		else if (take)
		begin
			addr_r <= req_addr_i;
			lanes_r <= req_lanes_i;
			write_r <= req_write_i;
		end

	// pin flops; selects move together, write strobe times the write
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			sel_n_r <= 1'b1;
			sel_r <= 1'b0;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			lane_n_r <= 2'h3;
			doe_n_r <= 2'h3;
			wdata_r <= asbc_pkg::DATA_RESET;
		end
		else
		begin
			sel_n_r <= sel_n_nxt;
			sel_r <= !sel_n_nxt;
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
			lane_n_r <= lane_n_nxt;
			doe_n_r <= doe_n_nxt;
			wdata_r <= wdata_nxt;
		end

	// read data capture of enabled lanes only, zero elsewhere
	wire read_end = (state_r == ST_READ) && cnt_done;
	wire [asbc_pkg::DATA_W-1:0] lane_mask = {{asbc_pkg::LANE_W{lanes_r[1]}},
		{asbc_pkg::LANE_W{lanes_r[0]}}};
	always_ff @(posedge clk_i or negedge rst_n)
		if (!rst_n)
		begin
			rdata_r <= asbc_pkg::DATA_RESET;
			rsp_valid_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			if (read_end)
				rdata_r <= data_i & lane_mask;
			rsp_valid_r <= read_end || ((state_r == ST_WRITE) && cnt_done);
			ready_r <= (state_nxt == ST_IDLE) && !retention_i;
		end

	assign req_ready_o = ready_r;
	assign rsp_valid_o = rsp_valid_r;
	assign rsp_rdata_o = rdata_r;
	assign mem_addr_o = addr_r;
	assign select_low_active_n_o = sel_n_r;
	assign select_high_active_o = sel_r;
	assign out_en_n_o = oe_n_r;
	assign write_en_n_o = we_n_r;
	assign lower_lane_en_n_o = lane_n_r[0];
	assign upper_lane_en_n_o = lane_n_r[1];
	assign data_o = wdata_r;
	assign data_oe_n_o = doe_n_r;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);
	chk_read_strobe_high: assert property (!out_en_n_o |-> write_en_n_o)
		else $error("write strobe low during read");
	chk_no_contention: assert property (!out_en_n_o |-> data_oe_n_o == 2'h3)
		else $error("host drives data while memory output enabled");
	chk_oe_release_gap: assert property ($rose(out_en_n_o) |-> (data_oe_n_o == 2'h3) [*4])
		else $error("host drove data too soon after read");
	chk_read_access: assert property ($fell(out_en_n_o) |-> !out_en_n_o [*8] ##1
		!out_en_n_o [*3] ##1 (out_en_n_o && rsp_valid_o))
		else $error("read not held for access time");
	chk_write_pulse: assert property ($fell(write_en_n_o) |-> !write_en_n_o [*8] ##1
		!write_en_n_o ##1 write_en_n_o)
		else $error("write pulse width wrong");
	chk_write_lanes: assert property (!write_en_n_o |-> data_oe_n_o == {upper_lane_en_n_o,
		lower_lane_en_n_o})
		else $error("driven lanes differ from enabled lanes");
	chk_addr_stable: assert property (!select_low_active_n_o && $past(!select_low_active_n_o)
		|-> $stable(mem_addr_o))
		else $error("address moved during access");
	chk_sel_pair: assert property (select_high_active_o == !select_low_active_n_o)
		else $error("selects disagree");
	chk_retain_idle: assert property (state_r == ST_RETAIN |-> select_low_active_n_o)
		else $error("access during retention");
	chk_recover_desel: assert property (state_r == ST_RECOVER |=> select_low_active_n_o)
		else $error("access during recovery");
	cov_read: cover property (rsp_valid_o && write_en_n_o && lanes_r == 2'h3);
	cov_write_low: cover property (!write_en_n_o && lower_lane_en_n_o == 1'b0
		&& upper_lane_en_n_o);
	cov_write_high: cover property (!write_en_n_o && upper_lane_en_n_o == 1'b0
		&& lower_lane_en_n_o);
	cov_retention: cover property (state_r == ST_RETAIN ##1 state_r == ST_RECOVER);
endmodule

/* File: dv/asbc_sram_model.sv */
`timescale 1ns/1ns
module asbc_sram_model (
	input wire logic [17:0] addr_i,
	input wire logic sel_n_i,
	input wire logic sel_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [1:0] lane_n_i,
	input wire logic [15:0] bus_i,
	output logic [15:0] q_o,
	output logic [1:0] drv_o
);
	logic [15:0] mem [0:262143];
	logic [15:0] bus_d;
	// both selects active, else standby with data kept
	wire chip_on = !sel_n_i && sel_i;
	wire wr_on = chip_on && !we_n_i;
	// drive enabled lanes only in a read
	assign drv_o = {2{chip_on && !oe_n_i && we_n_i}} & ~lane_n_i;
	assign q_o = mem[addr_i];
	// short hold so the release edge does not store the floating bus
	assign #1 bus_d = bus_i;
	// level write into each enabled lane
	always @*
	begin
		if (wr_on && !lane_n_i[0])
			mem[addr_i][7:0] = bus_d[7:0];
		if (wr_on && !lane_n_i[1])
			mem[addr_i][15:8] = bus_d[15:8];
	end
endmodule

/* File: dv/asbc_host_tb.sv */
`timescale 1ns/1ns
module asbc_host_tb;
	localparam int RCV = 8;
	// answer seen one edge after the last strobe cycle
	localparam int WR_LAT = asbc_pkg::WRITE_PULSE_CYC + 1;
	localparam int RD_LAT = asbc_pkg::READ_ACCESS_CYC + 1;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic retention_i = 1'b0;
	logic [17:0] req_addr_i = 18'h00000;
	logic [15:0] req_wdata_i = 16'h0000;
	logic [1:0] req_lanes_i = 2'h0;
	logic [15:0] noise_r = 16'h0000;
	logic [15:0] r;
	int n;
	int miscompares = 0;
	int tests_run = 0;
	wire ready, rsp, sel_n, sel, oe_n, we_n, lower_n, upper_n;
	wire [15:0] rdata, hd, q, bus;
	wire [17:0] addr;
	wire [1:0] hoe_n, drv;
	// wire level per lane: host, memory, or a changing float pattern
	assign bus[7:0] = !hoe_n[0] ? hd[7:0] : drv[0] ? q[7:0] : noise_r[7:0];
	assign bus[15:8] = !hoe_n[1] ? hd[15:8] : drv[1] ? q[15:8] : noise_r[15:8];
	asbc_host #(.RECOVERY_CYC(RCV)) asbc_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i), .req_lanes_i(req_lanes_i), .retention_i(retention_i),
		.req_ready_o(ready), .rsp_valid_o(rsp), .rsp_rdata_o(rdata), .mem_addr_o(addr),
		.select_low_active_n_o(sel_n), .select_high_active_o(sel), .out_en_n_o(oe_n),
		.write_en_n_o(we_n), .lower_lane_en_n_o(lower_n), .upper_lane_en_n_o(upper_n),
		.data_i(bus), .data_o(hd), .data_oe_n_o(hoe_n));
	asbc_sram_model asbc_sram_model_inst (.addr_i(addr), .sel_n_i(sel_n), .sel_i(sel),
		.oe_n_i(oe_n), .we_n_i(we_n), .lane_n_i({upper_n, lower_n}), .bus_i(bus), .q_o(q),
		.drv_o(drv));
	initial forever #4 clk_i = ~clk_i;
	task check_bit(input logic got, input logic exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			$display("[FAIL] %0t %s", $time, msg);
			miscompares++;
		end
	endtask
	task check_data(input logic [15:0] got, input logic [15:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			$display("[FAIL] %0t %s %h", $time, msg, got);
			miscompares++;
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one request, held until taken, then wait for the answer
	task access(input logic w, input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] l);
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_addr_i <= a;
		req_wdata_i <= d;
		req_lanes_i <= l;
		@(posedge clk_i);
		for (n = 0; n < 99 && ready !== 1'b1; n++)
			@(posedge clk_i);
		req_valid_i <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (rsp !== 1'b1 && n < 40);
		check_bit(n == (w ? WR_LAT : RD_LAT), 1'b1, "answer latency");
		r = rdata;
	endtask
	// request that must never start an access
	task refuse(input logic ret, input logic [1:0] l);
		@(posedge clk_i);
		retention_i <= ret;
		req_valid_i <= 1'b1;
		req_lanes_i <= l;
		repeat (20)
		begin
			@(posedge clk_i);
			check_bit(sel_n, 1'b1, "refused request selected memory");
		end
		check_bit(ready, !ret, "ready during refused request");
		req_valid_i <= 1'b0;
		retention_i <= 1'b0;
	endtask
	// pin rules watched every cycle once reset is let go
	always @(posedge clk_i)
		if (rst_n_i)
		begin
			noise_r <= ~bus;
			check_bit((~hoe_n & drv) == 2'h0, 1'b1, "data contention");
			check_bit(oe_n | we_n, 1'b1, "strobe low in read");
		end
	initial
	begin
		#100000;
		miscompares++;
		summarize;
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ready !== 1'b1 && n < 99);
		check_bit(n > RCV, 1'b1, "ready before recovery");
		access(1'b1, 18'h3FFFF, 16'hA1B2, 2'h3);
		access(1'b1, 18'h3FFFF, 16'hFFC3, 2'h1);
		access(1'b1, 18'h3FFFF, 16'hD4FF, 2'h2);
		access(1'b1, 18'h00000, 16'h5A69, 2'h3);
		access(1'b0, 18'h3FFFF, 16'h0000, 2'h3);
		check_data(r, 16'hD4C3, "word read");
		access(1'b0, 18'h3FFFF, 16'h0000, 2'h1);
		check_data(r, 16'h00C3, "lower read");
		access(1'b0, 18'h3FFFF, 16'h0000, 2'h2);
		check_data(r, 16'hD400, "upper read");
		refuse(1'b0, 2'h0);
		refuse(1'b1, 2'h3);
		access(1'b0, 18'h00000, 16'h0000, 2'h3);
		check_data(r, 16'h5A69, "contents after standby");
		summarize;
	end
endmodule
